// file: bench/psram_dev_model.sv
// behavioural memory device answering the host controller
`timescale 1ns/100ps
module psram_dev_model #(
	parameter int LAT = 4
) (
	input wire logic selectN,
	input wire logic linkClock,
	input wire logic clockComplement,
	input wire logic [7:0] dqLine,
	input wire logic strobeLine,
	input wire logic hostStrobeOe,
	input wire logic mute,
	output logic [7:0] devDq,
	output logic devDqOe,
	output logic devStrobe,
	output logic devStrobeOe,
	output logic [15:0] regWord,
	output logic [31:0] adr,
	output logic linearSeen,
	output int errCount
);
	import psram_pkg::*;
	logic [47:0] ca; // command bytes, top byte first
	logic [15:0] mem [16]; // tiny array, low address bits only
	logic [15:0] w; // word on its way in or out
	logic maskA; // upper byte masked
	int e; // link clock edges since select fell
	int k; // data edges after the latency
	int latE; // latency counted in edges
	realtime tDq; // last change on the data line
	realtime tUp; // last rise of select
	initial begin
		{devDq, devDqOe, devStrobe, devStrobeOe} = 11'h0;
		{regWord, adr, linearSeen} = 49'h0;
		errCount = 0;
		latE = 0;
		tDq = 0;
		tUp = -1000.0; // first select fall needs no recovery
	end
	// remember when the host last moved the data line
	always @(dqLine) tDq = $realtime;
	// select falls: strobe driven high so the latency doubles
	always @(negedge selectN) begin
		if (linkClock !== 1'b0 || clockComplement !== 1'b1) errCount++;
		if ($realtime - tUp < RECOVERY_TIME_NS) errCount++;
		e = 0;
		devStrobeOe = 1'b1;
		devStrobe = 1'b1;
	end
	// select rises: let go of both lines, showing the inverse level
	always @(posedge selectN) begin
		if (linkClock === 1'b1) errCount++;
		tUp = $realtime;
		devDqOe = 1'b0;
		devStrobeOe = 1'b0;
		devDq = ~devDq;
		devStrobe = ~devStrobe;
	end
	// every link clock edge; the small delay lets the complement settle
	always @(linkClock) begin
		#1;
		// the unknown-to-low step at reset is no clock activity
		if (selectN) begin
			if (linkClock !== 1'b0) errCount++;
		end else begin
			if (clockComplement !== ~linkClock) errCount++;
			k = e - 6 - latE;
			if (e < 6) ca = {ca[39:0], dqLine};
			if (e == 5) begin
				adr = {3'h0, ca[44:16], ca[2:0]};
				linearSeen = ca[45];
				latE = (!ca[47] && ca[46]) ? 0 : 4 * LAT;
				devStrobe = 1'b0; // reads hold it low, writes float
				devStrobeOe = ca[47];
			end else if (e > 5 && !ca[47]) begin
				if (k == -1 && latE > 0 && !(hostStrobeOe && !strobeLine))
					errCount++;
				if (k >= 0) begin
					if (latE == 0 && hostStrobeOe) errCount++;
					if ($realtime - tDq < 20) errCount++;
					if (!k[0]) begin
						w[15:8] = dqLine;
						maskA = strobeLine && latE > 0;
					end else begin
						w[7:0] = dqLine;
						if (ca[46]) regWord = w;
						else if (!maskA) mem[adr[3:0]][15:8] = w[15:8];
						if (!ca[46] && !(strobeLine && latE > 0))
							mem[adr[3:0]][7:0] = w[7:0];
						adr++;
					end
				end
			// a muted device holds the strobe low as a boundary stall
			end else if (e > 5 && k >= 0 && !mute) begin
				// wrapped bursts stay in an eight word group
				// linear past the array end just wraps the tiny array
				if (ca[45]) w = mem[4'(adr + 32'(k >>> 1))];
				else w = mem[{adr[3], adr[2:0] + 3'(k >>> 1)}];
				if (ca[46]) w = regWord;
				devStrobe = !k[0];
				devDqOe = 1'b1;
				devDq = k[0] ? w[7:0] : w[15:8];
			end
			e++;
		end
	end
endmodule

// file: bench/test_psram_ddr_bus_read_path.sv
// self-checking bench for the ddr pseudo-static RAM host controller
`timescale 1ns/100ps
module test_psram_ddr_bus_read_path;
	import psram_pkg::*;
	logic clk_sys, rst_n, hsel, hwrite, mute; // bench driven controls
	logic [31:0] haddr, hwdata, hrdata, stat, d, a; // bus values
	logic [1:0] htrans; // transfer type
	logic [2:0] hsize; // always a word
	logic hready, hreadyout, hresp; // bus answer
	logic selectN, linkClock, clockComplement; // link control pins
	logic [7:0] dqIn, dqOut, devDq; // data line parties
	logic dqOe, devDqOe, strobeMaskIn, strobeMaskOut; // enables, strobe
	logic strobeMaskOe, devStrobe, devStrobeOe, linearSeen; // model view
	logic [15:0] regWord; // register word seen by the device
	logic [31:0] devAdr; // word address seen by the device
	int devErr, failCount, checks; // tallies
	logic [4:0] pins; // idle view of the link pins
	assign pins = {selectN, linkClock, clockComplement, dqOe, strobeMaskOe};
	assign hready = hreadyout; // single slave
	// wire levels: whoever enables drives, else the model's idle value
	assign dqIn = dqOe ? dqOut : devDq;
	assign strobeMaskIn = strobeMaskOe ? strobeMaskOut : devStrobe;
	psram_host_ctrl psram_host_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .selectN(selectN),
		.linkClock(linkClock), .clockComplement(clockComplement),
		.dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
		.strobeMaskIn(strobeMaskIn), .strobeMaskOut(strobeMaskOut),
		.strobeMaskOe(strobeMaskOe));
	psram_dev_model #(.LAT(4)) psram_dev_model_i (.selectN(selectN),
		.linkClock(linkClock), .clockComplement(clockComplement),
		.dqLine(dqIn), .strobeLine(strobeMaskIn),
		.hostStrobeOe(strobeMaskOe), .mute(mute), .devDq(devDq),
		.devDqOe(devDqOe), .devStrobe(devStrobe),
		.devStrobeOe(devStrobeOe), .regWord(regWord), .adr(devAdr),
		.linearSeen(linearSeen), .errCount(devErr));
	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// verdict and end of run
	task automatic endOfTest;
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// compare and report
	task automatic check(input string what, input logic [31:0] exp, got);
		checks++;
		if (exp !== got) begin
			failCount++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// wait for hready at a rising edge, bounded
	task automatic waitReady;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failCount++;
			endOfTest;
		end
	endtask
	// one single word transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] ofs,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, ofs};
		hwrite <= wr;
		waitReady;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady;
		rd = hrdata;
	endtask
	// program and start one link transfer, then poll until it ends
	task automatic xfer(input logic rd, sp, wrp, input logic [31:0] ad, wd);
		int n;
		bus(1'b1, OFS_ADDR, ad, d);
		bus(1'b1, OFS_WDATA, wd, d);
		bus(1'b1, OFS_CTRL, {20'h0, 4'h4, 4'h0, wrp, sp, rd, 1'b1}, d);
		n = 0;
		do begin
			bus(1'b0, OFS_STATUS, 32'h0, stat);
			n++;
		// wait on busy: a stale timeout flag stands until the start is taken
		end while (stat[ST_BUSY] !== 1'b0 && n < 600);
		if (n >= 600) begin
			failCount++;
			endOfTest;
		end
	endtask
	// main sequence
	initial begin
		{rst_n, hsel, hwrite, mute, haddr, htrans, hwdata} = 70'h0;
		hsize = 3'h2;
		failCount = 0;
		checks = 0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0, d);
		check("ctrl reset", 32'h600, d);
		bus(1'b0, OFS_STATUS, 32'h0, d);
		check("status reset", 32'h0, d);
		bus(1'b0, 8'h20, 32'h0, d);
		check("unmapped", 32'h0, d);
		check("idle pins", 32'h14, {27'h0, pins});
		$display("test reset done");
		xfer(1'b0, 1'b1, 1'b0, 32'h0, 32'hc3a5);
		check("register write", 32'hc3a5, {16'h0, regWord});
		xfer(1'b1, 1'b1, 1'b0, 32'h0, 32'h0);
		check("read status", 32'h6, stat);
		bus(1'b0, OFS_RDATA, 32'h0, d);
		check("register read", 32'hc3a5, {16'h0, d[15:0]});
		$display("test register space done");
		for (int m = 0; m < 4; m++) begin
			a = 32'h0abc_de08 + 32'(m) * 5;
			xfer(1'b0, 1'b0, 1'b1, a, 32'h0f0f);
			xfer(1'b0, 1'b0, 1'b1, a, {14'h0, 2'(m), 16'ha55a});
			xfer(1'b1, 1'b0, m[0], a, 32'h0);
			bus(1'b0, OFS_RDATA, 32'h0, d);
			check("masked word", {16'h0, m[0] ? 8'h0f : 8'ha5,
				m[1] ? 8'h0f : 8'h5a}, {16'h0, d[15:0]});
			check("burst type", {31'h0, !m[0]}, {31'h0, linearSeen});
			check("word address", a, devAdr);
		end
		$display("test memory masks done");
		mute <= 1'b1;
		xfer(1'b1, 1'b0, 1'b0, 32'h0abc_de08, 32'h0);
		check("silent device", 32'h8, stat & 32'h9);
		mute <= 1'b0;
		xfer(1'b1, 1'b0, 1'b0, 32'h0abc_de08, 32'h0);
		bus(1'b0, OFS_RDATA, 32'h0, d);
		check("after timeout", 32'ha55a, {16'h0, d[15:0]});
		$display("test read timeout done");
		check("released pins", 32'h14, {27'h0, pins});
		check("link protocol", 32'h0, 32'(devErr));
		endOfTest;
	end
endmodule

// file: hw/psram_host_ctrl.sv
// host controller for the eight-bit ddr pseudo-static RAM bus
`timescale 1ns/100ps
module psram_host_ctrl (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic selectN,
	output logic linkClock,
	output logic clockComplement,
	input wire logic [7:0] dqIn,
	output logic [7:0] dqOut,
	output logic dqOe,
	input wire logic strobeMaskIn,
	output logic strobeMaskOut,
	output logic strobeMaskOe
);
	import psram_pkg::*;

	// software-visible state
	psram_pkg::xferCtrl_t ctrl_q; // transfer settings
	logic [31:0] addr_q; // word address of the transfer
	logic [17:0] wdata_q; // write word plus byte masks
	logic [15:0] rdata_q; // last word read back
	logic startReq_q; // start pending for the sequencer
	logic done_q; // sticky: transfer finished
	logic doubled_q; // last transfer saw doubled latency
	logic tmo_q; // read strobe never arrived
	// bus slave bookkeeping
	logic wrPend_q; // write data phase follows
	logic [DEC_W-1:0] wrAddr_q; // offset latched in address phase
	logic [31:0] rdMux; // read value for the current address
	logic addrPhase; // a valid transfer is being offered
	// link sequencer
	linkState_t state_q;
	logic [1:0] phase_q; // position inside one link clock
	logic [2:0] caIdx_q; // command-address byte count
	logic [6:0] latCnt_q; // latency byte slots left
	logic wByte_q; // which write byte goes next
	logic rByte_q; // which read byte comes next
	logic [7:0] rdWait_q; // slots spent waiting for read data
	logic [3:0] recCnt_q; // recovery cycles still to wait
	logic active; // link clock is running
	logic tick; // a byte slot boundary
	logic ckNext; // next link clock level
	logic accept; // sequencer takes a start request
	logic finish; // sequencer closes the transfer
	psram_pkg::commandAddressWord_t caWord;
	logic [7:0] caByte;
	logic memWrite; // write with latency and masks
	// synchronised read side
	logic [8:0] pinSync; // strobe and data after two flops
	logic strobePrev_q; // previous synchronised strobe
	logic strobeEdge;

	// strobe and data come from the device's domain
	psram_sync2 #(
		.W(9)
	) u_pinSync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din({strobeMaskIn, dqIn}),
		.dout(pinSync)
	);

	// answer every access at once with OKAY
	assign addrPhase = hsel && hready && htrans[1];
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// register read mux, unmapped offsets read zero
	always_comb begin
		case (haddr[DEC_W-1:0])
			OFS_CTRL: rdMux = {20'h0, ctrl_q.latency, 4'h0,
				ctrl_q.wrapped, ctrl_q.regSpace, ctrl_q.isRead, 1'b0};
			OFS_ADDR: rdMux = addr_q;
			OFS_WDATA: rdMux = {14'h0, wdata_q};
			OFS_RDATA: rdMux = {16'h0, rdata_q};
			OFS_STATUS: rdMux = {28'h0, tmo_q, doubled_q, done_q,
				(state_q != S_IDLE) || startReq_q};
			default: rdMux = 32'h0;
		endcase
	end

	// read data is registered in the address phase for zero wait
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hrdata <= 32'h0;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdMux;
		end
	end

	// remember writes until their data phase
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= '0;
		end else if (hready) begin
			wrPend_q <= addrPhase && hwrite;
			wrAddr_q <= haddr[DEC_W-1:0];
		end
	end

	// software settings; hsize is ignored, only words are used
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_q <= '{latency: LAT_RESET, default: 1'b0};
			addr_q <= 32'h0;
			wdata_q <= 18'h0;
		end else if (wrPend_q) begin
			case (wrAddr_q)
				OFS_CTRL: begin
					ctrl_q.latency <= hwdata[CTRL_LAT_MSB:CTRL_LAT_LSB];
					ctrl_q.wrapped <= hwdata[CTRL_WRAP];
					ctrl_q.regSpace <= hwdata[CTRL_SPACE];
					ctrl_q.isRead <= hwdata[CTRL_READ];
				end
				OFS_ADDR: addr_q <= hwdata;
				OFS_WDATA: wdata_q <= hwdata[MASK_B:0];
				default: begin
				end
			endcase
		end
	end

	// start request: a new start wins over the sequencer taking it
	assign accept = (state_q == S_IDLE) && startReq_q && (recCnt_q == 4'h0);
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			startReq_q <= 1'b0;
		end else if (wrPend_q && (wrAddr_q == OFS_CTRL)
			&& hwdata[CTRL_START] && (state_q == S_IDLE)) begin
			startReq_q <= 1'b1;
		end else if (accept) begin
			startReq_q <= 1'b0;
		end
	end

	// done is sticky; a finishing transfer beats the clearing start
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else if (finish) begin
			done_q <= 1'b1;
		end else if (wrPend_q && (wrAddr_q == OFS_CTRL) && hwdata[CTRL_START]) begin
			done_q <= 1'b0;
		end
	end

	// command-address word: read, space and burst type on top
	assign caWord = '{isRead: ctrl_q.isRead, regSpace: ctrl_q.regSpace,
		linear: !ctrl_q.wrapped, addrHigh: addr_q[31:3],
		reserved: 13'h0, addrLow: addr_q[2:0]};
	assign caByte = caWord[(CA_W - 1 - 8 * caIdx_q) -: 8];
	assign memWrite = !ctrl_q.isRead && !ctrl_q.regSpace;

	// the link clock runs in the busy states only
	assign active = (state_q != S_IDLE);
	assign tick = active && phase_q[0];
	assign ckNext = active && ((phase_q == PH_CK_HI_A) || (phase_q == PH_CK_HI_B));
	assign strobeEdge = (pinSync[8] != strobePrev_q);
	assign finish = (state_q == S_END) && (phase_q == PH_LAST);

	// phase counter; starting at the last phase keeps clock low at select
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			phase_q <= 2'h0;
		end else if (accept) begin
			phase_q <= PH_START;
		end else if (active) begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// true and complement clock from flops, never out of step
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			linkClock <= 1'b0;
			clockComplement <= 1'b1;
		end else begin
			linkClock <= ckNext;
			clockComplement <= !ckNext;
		end
	end

	// recovery gap between select rising and the next select falling
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			recCnt_q <= 4'h0;
		end else if (finish) begin
			recCnt_q <= REC_CNT;
		end else if (recCnt_q != 4'h0) begin
			recCnt_q <= recCnt_q - 4'h1;
		end
	end

	// previous strobe for edge finding on the synchronised copy
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			strobePrev_q <= 1'b0;
		end else begin
			strobePrev_q <= pinSync[8];
		end
	end

	// main link sequencer; data moves one system cycle before each clock edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			selectN <= 1'b1;
			dqOut <= 8'h0;
			dqOe <= 1'b0;
			strobeMaskOut <= 1'b0;
			strobeMaskOe <= 1'b0;
			caIdx_q <= 3'h0;
			latCnt_q <= 7'h0;
			wByte_q <= 1'b0;
			rByte_q <= 1'b0;
			rdWait_q <= 8'h0;
			doubled_q <= 1'b0;
			tmo_q <= 1'b0;
			rdata_q <= 16'h0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (accept) begin
						selectN <= 1'b0;
						caIdx_q <= 3'h0;
						tmo_q <= 1'b0;
						state_q <= S_CMD;
					end
				end
				S_CMD: begin
					if (tick) begin
						dqOut <= caByte;
						dqOe <= 1'b1;
						caIdx_q <= caIdx_q + 3'h1;
						if (caIdx_q == CA_LAST) begin
							// strobe high in the command phase doubles latency
							doubled_q <= pinSync[8];
							latCnt_q <= pinSync[8] ? {1'b0, ctrl_q.latency, 2'h0}
								: {2'h0, ctrl_q.latency, 1'b0};
							wByte_q <= 1'b0;
							rByte_q <= 1'b0;
							rdWait_q <= 8'h0;
							// register writes carry no latency
							state_q <= (!ctrl_q.isRead && ctrl_q.regSpace)
								? S_WRITE : S_LAT;
						end
					end
				end
				S_LAT: begin
					if (tick) begin
						dqOe <= 1'b0;
						// last latency clock: low mask preamble for writes
						if (memWrite && (latCnt_q <= 7'h2)) begin
							strobeMaskOut <= 1'b0;
							strobeMaskOe <= 1'b1;
						end
						latCnt_q <= latCnt_q - 7'h1;
						if (latCnt_q <= 7'h1) begin
							state_q <= ctrl_q.isRead ? S_READ : S_WRITE;
						end
					end
				end
				S_WRITE: begin
					if (tick) begin
						dqOe <= 1'b1;
						// upper byte on the rise, lower on the fall
						dqOut <= wByte_q ? wdata_q[7:0] : wdata_q[15:8];
						if (memWrite) begin
							strobeMaskOut <= wByte_q ? wdata_q[MASK_B]
								: wdata_q[MASK_A];
							strobeMaskOe <= 1'b1;
						end else begin
							strobeMaskOe <= 1'b0;
						end
						wByte_q <= 1'b1;
						if (wByte_q) begin
							state_q <= S_END;
						end
					end
				end
				S_READ: begin
					// clock keeps running; strobe may pause at boundaries
					if (strobeEdge) begin
						rByte_q <= 1'b1;
						if (!rByte_q) begin
							rdata_q[15:8] <= pinSync[7:0];
						end else begin
							rdata_q[7:0] <= pinSync[7:0];
							state_q <= S_END;
						end
					end else if (tick) begin
						rdWait_q <= rdWait_q + 8'h1;
						if (rdWait_q == READ_TIMEOUT_SLOTS) begin
							tmo_q <= 1'b1;
							state_q <= S_END;
						end
					end
				end
				S_END: begin
					// select rises in the phase where the clock is low
					if (phase_q == PH_LAST) begin
						selectN <= 1'b1;
						dqOe <= 1'b0;
						strobeMaskOe <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// checks on the pins this controller drives
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_select_fall_idle: assert property (
		$fell(selectN) |-> !linkClock && clockComplement)
		else $error("select fell while clock not idle");
	a_select_rise_idle: assert property (
		$rose(selectN) |-> !linkClock)
		else $error("select rose while clock high");
	a_clock_idle_desel: assert property (
		selectN |-> !linkClock)
		else $error("clock high while deselected");
	a_clock_complement: assert property (
		clockComplement != linkClock)
		else $error("complement clock not inverse");
	a_data_centred: assert property (
		(!selectN && dqOe && $changed(dqOut)) |-> $stable(linkClock))
		else $error("data changed on a clock edge");
	a_zero_lat_float: assert property (
		(state_q == S_WRITE && ctrl_q.regSpace) |-> !strobeMaskOe)
		else $error("strobe driven in zero latency write");
	a_mask_preamble: assert property (
		($rose(state_q == S_WRITE) && memWrite)
		|-> strobeMaskOe && !strobeMaskOut)
		else $error("no low mask preamble");
	a_mask_driven: assert property (
		(state_q == S_WRITE && memWrite) |-> strobeMaskOe)
		else $error("mask not driven in latency write");
	a_recovery_gap: assert property (
		$rose(selectN) |-> selectN[*3])
		else $error("recovery gap too short");

	c_read_done: cover property (
		(state_q == S_READ) ##[1:400] $rose(selectN));
	c_mem_write: cover property (
		(state_q == S_WRITE && memWrite) ##[1:20] $rose(selectN));
	c_reg_write: cover property (
		$rose(state_q == S_WRITE) && ctrl_q.regSpace);
	c_doubled_lat: cover property ($rose(doubled_q));
endmodule

// file: hw/psram_pkg.sv
// shared constants, types and register map for the pseudo-static RAM host
package psram_pkg;
	// system clock and link timing
	localparam int unsigned SYS_PERIOD_NS = 25;
	localparam int unsigned RECOVERY_TIME_NS = 40;
	localparam int unsigned RECOVERY_CYC =
		(RECOVERY_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [3:0] REC_CNT = 4'(RECOVERY_CYC);
	// read strobe must move within this many byte slots
	localparam logic [7:0] READ_TIMEOUT_SLOTS = 8'hc8;
	// link clock phases (four system cycles per link clock)
	localparam logic [1:0] PH_START = 2'h3;
	localparam logic [1:0] PH_CK_HI_A = 2'h0;
	localparam logic [1:0] PH_CK_HI_B = 2'h1;
	localparam logic [1:0] PH_LAST = 2'h3;
	// command-address byte handling
	localparam logic [2:0] CA_LAST = 3'h5;
	localparam int unsigned CA_W = 48;
	// register offsets on the AHB-Lite side
	localparam int unsigned DEC_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_RDATA = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// control register fields
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_READ = 1;
	localparam int unsigned CTRL_SPACE = 2;
	localparam int unsigned CTRL_WRAP = 3;
	localparam int unsigned CTRL_LAT_LSB = 8;
	localparam int unsigned CTRL_LAT_MSB = 11;
	// write data register: word in low half, byte masks above
	localparam int unsigned MASK_A = 16;
	localparam int unsigned MASK_B = 17;
	// status register fields and the control reset latency
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_DONE = 1;
	localparam int unsigned ST_DOUBLE = 2;
	localparam int unsigned ST_TMO = 3;
	localparam logic [3:0] LAT_RESET = 4'h6;
	// transfer settings held by software
	typedef struct packed {
		logic [3:0] latency;
		logic wrapped;
		logic regSpace;
		logic isRead;
	} xferCtrl_t;
	// the 48-bit command-address word, sent top byte first
	typedef struct packed {
		logic isRead;
		logic regSpace;
		logic linear;
		logic [28:0] addrHigh;
		logic [12:0] reserved;
		logic [2:0] addrLow;
	} commandAddressWord_t;
	// link sequencer states
	typedef enum logic [2:0] {
		S_IDLE, S_CMD, S_LAT, S_WRITE, S_READ, S_END
	} linkState_t;
endpackage

// file: hw/psram_sync2.sv
// two flip-flop synchroniser for pins arriving from the memory
`timescale 1ns/100ps
module psram_sync2 #(
	parameter int unsigned W = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q; // first stage, read only by the second
	// plain double register, no logic between stages
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule
